// ==== rcec_top.v ====
// Retirement and pipeline-clear qualification, clear generation and event counting
`include "rcec_consts.vh"
`default_nettype none

// Behaviour
// - Instruction event 00H counts once per instruction, on its last micro-op.
// - Instruction counting continues through interrupts, traps and handlers.
// - Fixed counter zero counts retired instructions with no selection.
// - C2H/01H counts retired micro-ops from the microcode sequencer ROM.
// - C2H/02H counts retired micro-ops that used floating-point stack hardware.
// - C2H/04H counts retired micro-ops that used the multiplier.
// - C2H/08H counts retired micro-ops that used the divider.
// - C2H/10H counts every retired micro-op.
// - Clear event 01H counts self-modifying code detections.
// - Clear event 02H counts memory-ordering clears.
// - Clear event 04H counts floating-point assist clears.
// - Clear event 08H counts every machine clear of any cause.
// - Any-cause clears include interrupts, traps and faults too.
// - Code-write detection compares store and code addresses per 1K region.
// - After a code-write clear, stores drain before the front end restarts.
// - Floating-point result needing help raises a clear and requests an assist.
// - Snoop hitting early-done younger load with older pending forces clear and undo.
// - No older load pending means no ordering clear for that snoop.
module rcec_top #(
   parameter CNT_W = `RCEC_CNT_W,
   parameter ADDR_W = 48,
   parameter NUM_PROG = 2
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Counter selection and control, from core logic
   input wire [NUM_PROG*8-1:0] prog_event_num,
   input wire [NUM_PROG*8-1:0] prog_unit_mask,
   input wire [NUM_PROG-1:0] prog_clear,
   input wire fixed_clear,
   // Retirement, one micro-op per cycle
   input wire uop_retire_valid,
   input wire uop_retire_last,
   input wire uop_from_rom,
   input wire uop_fp_stack,
   input wire uop_multiplier,
   input wire uop_divider,
   // Self-modifying code detection
   input wire store_valid,
   input wire [ADDR_W-1:0] store_addr,
   input wire code_valid,
   input wire [ADDR_W-1:0] code_addr,
   input wire store_buffer_empty,
   // Floating-point help request
   input wire fp_result_needs_help,
   // Memory ordering
   input wire snoop_hit_done_load,
   input wire older_load_pending,
   // Other clear causes: interrupt, trap, fault
   input wire other_clear,
   // Clear and restart control to the pipeline
   output reg machine_clear_q,
   output reg undo_to_load_q,
   output reg fp_assist_start_q,
   output reg front_end_hold_q,
   // Counts
   output wire [NUM_PROG*CNT_W-1:0] prog_count,
   output wire [CNT_W-1:0] fixed_count
);
   // ------------------------------------------------------------
   // Clear cause detection
   // ------------------------------------------------------------
   wire code_hit;
   wire order_hit;
   wire clear_any;
   reg code_clear_q;
   reg order_clear_q;
   reg fphelp_clear_q;
   reg any_clear_q;
   reg drain_q;
   reg drain_d;

   wire [ADDR_W-`RCEC_REGION_LSB-1:0] store_region;
   wire [ADDR_W-`RCEC_REGION_LSB-1:0] code_region;
   wire region_match;

   assign store_region = store_addr[ADDR_W-1:`RCEC_REGION_LSB];
   assign code_region = code_addr[ADDR_W-1:`RCEC_REGION_LSB];
   assign region_match = (store_region == code_region);

   // Region compare only; a store near code may clear without touching it
   assign code_hit = store_valid && code_valid && region_match;
   assign order_hit = snoop_hit_done_load && older_load_pending;
   assign clear_any = code_hit || order_hit || fp_result_needs_help || other_clear;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         code_clear_q <= 1'b0;
         order_clear_q <= 1'b0;
         fphelp_clear_q <= 1'b0;
         any_clear_q <= 1'b0;
         machine_clear_q <= 1'b0;
         undo_to_load_q <= 1'b0;
         fp_assist_start_q <= 1'b0;
      end else begin
         code_clear_q <= code_hit;
         order_clear_q <= order_hit;
         fphelp_clear_q <= fp_result_needs_help;
         any_clear_q <= clear_any;
         machine_clear_q <= clear_any;
         undo_to_load_q <= order_hit;
         fp_assist_start_q <= fp_result_needs_help;
      end
   end

   // ------------------------------------------------------------
   // Store drain before restart
   // ------------------------------------------------------------
   // Hold the front end until stores drain so refetch sees the new code
   always @* begin
      drain_d = drain_q;
      if (code_hit) begin
         drain_d = 1'b1;
      end else if (store_buffer_empty) begin
         drain_d = 1'b0;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         drain_q <= 1'b0;
         front_end_hold_q <= 1'b0;
      end else begin
         drain_q <= drain_d;
         front_end_hold_q <= drain_d;
      end
   end

   // ------------------------------------------------------------
   // Event qualification, registered so counts are one cycle behind
   // ------------------------------------------------------------
   reg inst_q;
   reg uop_q;
   reg rom_q;
   reg fps_q;
   reg mul_q;
   reg div_q;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         inst_q <= 1'b0;
         uop_q <= 1'b0;
         rom_q <= 1'b0;
         fps_q <= 1'b0;
         mul_q <= 1'b0;
         div_q <= 1'b0;
      end else begin
         // No interrupt or handler gating: counting never pauses
         inst_q <= uop_retire_valid && uop_retire_last;
         uop_q <= uop_retire_valid;
         rom_q <= uop_retire_valid && uop_from_rom;
         fps_q <= uop_retire_valid && uop_fp_stack;
         mul_q <= uop_retire_valid && uop_multiplier;
         div_q <= uop_retire_valid && uop_divider;
      end
   end

   // ------------------------------------------------------------
   // Selection per programmable counter
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_PROG; g = g + 1) begin : g_prog
         // Decode is registered so it lines up with the registered qualifiers
         wire [7:0] evn;
         wire [7:0] um;
         reg sel_inst_d;
         reg sel_uop_d;
         reg sel_rom_d;
         reg sel_fps_d;
         reg sel_mul_d;
         reg sel_div_d;
         reg sel_code_d;
         reg sel_order_d;
         reg sel_fp_d;
         reg sel_any_d;
         reg sel_inst_q;
         reg sel_uop_q;
         reg sel_rom_q;
         reg sel_fps_q;
         reg sel_mul_q;
         reg sel_div_q;
         reg sel_code_q;
         reg sel_order_q;
         reg sel_fp_q;
         reg sel_any_q;
         reg hit;

         assign evn = prog_event_num[g*8 +: 8];
         assign um = prog_unit_mask[g*8 +: 8];

         always @* begin
            sel_inst_d = 1'b0;
            sel_uop_d = 1'b0;
            sel_rom_d = 1'b0;
            sel_fps_d = 1'b0;
            sel_mul_d = 1'b0;
            sel_div_d = 1'b0;
            sel_code_d = 1'b0;
            sel_order_d = 1'b0;
            sel_fp_d = 1'b0;
            sel_any_d = 1'b0;
            case (evn)
               `RCEC_EVT_INST_RET: begin
                  sel_inst_d = (um == `RCEC_UM_INST_ANY);
               end
               `RCEC_EVT_UOPS_RET: begin
                  case (um)
                     `RCEC_UM_UOP_ROM: begin
                        sel_rom_d = 1'b1;
                     end
                     `RCEC_UM_UOP_FPSTACK: begin
                        sel_fps_d = 1'b1;
                     end
                     `RCEC_UM_UOP_MUL: begin
                        sel_mul_d = 1'b1;
                     end
                     `RCEC_UM_UOP_DIV: begin
                        sel_div_d = 1'b1;
                     end
                     `RCEC_UM_UOP_ANY: begin
                        sel_uop_d = 1'b1;
                     end
                     default: begin
                        sel_uop_d = 1'b0;
                     end
                  endcase
               end
               `RCEC_EVT_CLEARS: begin
                  case (um)
                     `RCEC_UM_CLR_CODE: begin
                        sel_code_d = 1'b1;
                     end
                     `RCEC_UM_CLR_ORDER: begin
                        sel_order_d = 1'b1;
                     end
                     `RCEC_UM_CLR_FPHELP: begin
                        sel_fp_d = 1'b1;
                     end
                     `RCEC_UM_CLR_ANY: begin
                        sel_any_d = 1'b1;
                     end
                     default: begin
                        sel_any_d = 1'b0;
                     end
                  endcase
               end
               default: begin
                  sel_inst_d = 1'b0;
               end
            endcase
         end

         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               sel_inst_q <= 1'b0;
               sel_uop_q <= 1'b0;
               sel_rom_q <= 1'b0;
               sel_fps_q <= 1'b0;
               sel_mul_q <= 1'b0;
               sel_div_q <= 1'b0;
               sel_code_q <= 1'b0;
               sel_order_q <= 1'b0;
               sel_fp_q <= 1'b0;
               sel_any_q <= 1'b0;
            end else begin
               sel_inst_q <= sel_inst_d;
               sel_uop_q <= sel_uop_d;
               sel_rom_q <= sel_rom_d;
               sel_fps_q <= sel_fps_d;
               sel_mul_q <= sel_mul_d;
               sel_div_q <= sel_div_d;
               sel_code_q <= sel_code_d;
               sel_order_q <= sel_order_d;
               sel_fp_q <= sel_fp_d;
               sel_any_q <= sel_any_d;
            end
         end

         // Unmatched pairs leave every select low, so nothing counts
         always @* begin
            hit = 1'b0;
            if (sel_inst_q && inst_q) begin
               hit = 1'b1;
            end
            if (sel_uop_q && uop_q) begin
               hit = 1'b1;
            end
            if (sel_rom_q && rom_q) begin
               hit = 1'b1;
            end
            if (sel_fps_q && fps_q) begin
               hit = 1'b1;
            end
            if (sel_mul_q && mul_q) begin
               hit = 1'b1;
            end
            if (sel_div_q && div_q) begin
               hit = 1'b1;
            end
            if (sel_code_q && code_clear_q) begin
               hit = 1'b1;
            end
            if (sel_order_q && order_clear_q) begin
               hit = 1'b1;
            end
            if (sel_fp_q && fphelp_clear_q) begin
               hit = 1'b1;
            end
            if (sel_any_q && any_clear_q) begin
               hit = 1'b1;
            end
         end

         rcec_counter #(
            .W(CNT_W)
         ) u_prog (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .clr(prog_clear[g]),
            .inc(hit),
            .count_q(prog_count[g*CNT_W +: CNT_W])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Fixed counter zero
   // ------------------------------------------------------------
   rcec_counter #(
      .W(CNT_W)
   ) u_fixed (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clr(fixed_clear),
      .inc(inst_q),
      .count_q(fixed_count)
   );
endmodule
`default_nettype wire

// ==== rcec_consts.vh ====
// Event numbers, unit masks and widths for the retirement and clear event counter
`ifndef RCEC_CONSTS_VH
`define RCEC_CONSTS_VH

`define RCEC_EVT_INST_RET 8'hC0
`define RCEC_EVT_UOPS_RET 8'hC2
`define RCEC_EVT_CLEARS 8'hC3

`define RCEC_UM_INST_ANY 8'h00
`define RCEC_UM_UOP_ROM 8'h01
`define RCEC_UM_UOP_FPSTACK 8'h02
`define RCEC_UM_UOP_MUL 8'h04
`define RCEC_UM_UOP_DIV 8'h08
`define RCEC_UM_UOP_ANY 8'h10
`define RCEC_UM_CLR_CODE 8'h01
`define RCEC_UM_CLR_ORDER 8'h02
`define RCEC_UM_CLR_FPHELP 8'h04
`define RCEC_UM_CLR_ANY 8'h08

`define RCEC_REGION_LSB 10
`define RCEC_CNT_W 48
`define RCEC_CNT_RESET 48'h000000000000

`endif

// ==== rcec_counter.v ====
// Event counter with synchronous clear, one count per qualifying occurrence
`default_nettype none
module rcec_counter #(
   parameter W = 48
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Control
   input wire clr,
   input wire inc,
   // Count
   output reg [W-1:0] count_q
);
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= {W{1'b0}};
      end else if (clr) begin
         count_q <= {W{1'b0}};
      end else if (inc) begin
         count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

// ==== rcec_props.sv ====
// Timing checks on the retirement and clear event counter outputs
`default_nettype none
module rcec_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Causes
   input wire logic uop_retire_valid,
   input wire logic uop_retire_last,
   input wire logic store_valid,
   input wire logic [47:0] store_addr,
   input wire logic code_valid,
   input wire logic [47:0] code_addr,
   input wire logic store_buffer_empty,
   input wire logic fp_result_needs_help,
   input wire logic snoop_hit_done_load,
   input wire logic older_load_pending,
   input wire logic other_clear,
   input wire logic fixed_clear,
   // Results
   input wire logic machine_clear_q,
   input wire logic undo_to_load_q,
   input wire logic fp_assist_start_q,
   input wire logic front_end_hold_q,
   input wire logic [47:0] fixed_count
);
   wire logic code_hit = store_valid & code_valid & (store_addr[47:10] == code_addr[47:10]);
   wire logic ord_hit = snoop_hit_done_load & older_load_pending;
   wire logic inst = uop_retire_valid & uop_retire_last;
   wire logic cause = code_hit | ord_hit | fp_result_needs_help | other_clear;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_code_clear: assert property (code_hit |=> machine_clear_q && front_end_hold_q)
      else $error("code write gave no clear");
   a_order_undo: assert property (ord_hit |=> undo_to_load_q && machine_clear_q)
      else $error("ordering hit gave no undo");
   a_order_none: assert property (!ord_hit |=> !undo_to_load_q)
      else $error("undo without pending older load");
   a_fp_assist: assert property (fp_result_needs_help |=> fp_assist_start_q && machine_clear_q)
      else $error("float help gave no assist");
   a_other_clear: assert property (other_clear |=> machine_clear_q)
      else $error("other cause gave no clear");
   a_no_cause: assert property (!cause |=> !machine_clear_q)
      else $error("clear without cause");
   a_hold_drain: assert property (front_end_hold_q && !store_buffer_empty |=> front_end_hold_q)
      else $error("front end released before drain");
   a_hold_release: assert property (front_end_hold_q && store_buffer_empty && !code_hit |=> !front_end_hold_q)
      else $error("front end held after drain");
   a_inst_count: assert property (inst ##1 !fixed_clear |=> fixed_count == $past(fixed_count) + 48'h1)
      else $error("fixed count missed an instruction");
   a_inst_idle: assert property (!inst ##1 !fixed_clear |=> $stable(fixed_count))
      else $error("fixed count moved without instruction");
endmodule
bind rcec_top rcec_props chk_u (.*);
`default_nettype wire

// ==== rcec_core_model.sv ====
// Stand-in for core retirement and pipeline control feeding the counter
`default_nettype none
module rcec_core_model (
   // Clock and enable
   input wire logic clk_sys,
   input wire logic act,
   // Retirement and clear causes
   output logic uop_retire_valid,
   output logic uop_retire_last,
   output logic uop_from_rom,
   output logic uop_fp_stack,
   output logic uop_multiplier,
   output logic uop_divider,
   output logic store_valid,
   output logic [47:0] store_addr,
   output logic code_valid,
   output logic [47:0] code_addr,
   output logic store_buffer_empty,
   output logic fp_result_needs_help,
   output logic snoop_hit_done_load,
   output logic older_load_pending,
   output logic other_clear
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 41;
   logic [31:0] r;
   logic [31:0] a;
   logic en;
   initial forever begin
      r = $random(seed);
      a = $random(seed);
      en = act === 1'b1;
      uop_retire_valid <= en & r[0];
      uop_retire_last <= r[1] | r[2];
      uop_from_rom <= r[3];
      uop_fp_stack <= r[4];
      uop_multiplier <= r[5];
      uop_divider <= r[6];
      store_valid <= en & r[7];
      code_valid <= en & r[8];
      store_addr <= {a[15:0], r};
      // Bit 10 flip lands just outside the region
      code_addr <= {a[15:0], r} ^ (r[17] ? 48'h400 : {38'h0, a[25:16]});
      store_buffer_empty <= r[9] | r[10];
      fp_result_needs_help <= en & r[11] & r[12];
      snoop_hit_done_load <= en & r[13];
      older_load_pending <= en & r[14];
      other_clear <= en & r[15] & r[16];
      @(negedge clk_sys);
   end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the retirement and clear event counter
`include "rcec_consts.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_n, fixed_clear, act;
   logic [15:0] prog_event_num, prog_unit_mask;
   logic [1:0] prog_clear;
   wire logic uop_retire_valid, uop_retire_last, uop_from_rom, uop_fp_stack, uop_multiplier, uop_divider;
   wire logic store_valid, code_valid, store_buffer_empty, fp_result_needs_help;
   wire logic snoop_hit_done_load, older_load_pending, other_clear;
   wire logic machine_clear_q, undo_to_load_q, fp_assist_start_q, front_end_hold_q;
   wire logic [47:0] store_addr, code_addr, fixed_count;
   wire logic [95:0] prog_count;
   logic [47:0] want[2];
   logic [47:0] efix;
   logic ehold;
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   // Last two pairs must never count
   logic [15:0] tab[12] = '{16'hC000, 16'hC201, 16'hC202, 16'hC204, 16'hC208, 16'hC210,
      16'hC301, 16'hC302, 16'hC304, 16'hC308, 16'hC001, 16'hC300};
   rcec_top dut_u (.*);
   rcec_core_model core_u (.*);
   function automatic bit hit(input logic [15:0] sel);
      logic cw;
      cw = store_valid & code_valid & (store_addr[47:10] == code_addr[47:10]);
      case (sel)
         16'hC000: hit = uop_retire_valid & uop_retire_last;
         16'hC201: hit = uop_retire_valid & uop_from_rom;
         16'hC202: hit = uop_retire_valid & uop_fp_stack;
         16'hC204: hit = uop_retire_valid & uop_multiplier;
         16'hC208: hit = uop_retire_valid & uop_divider;
         16'hC210: hit = uop_retire_valid;
         16'hC301: hit = cw;
         16'hC302: hit = snoop_hit_done_load & older_load_pending;
         16'hC304: hit = fp_result_needs_help;
         16'hC308: hit = cw | (snoop_hit_done_load & older_load_pending) | fp_result_needs_help | other_clear;
         default: hit = 1'b0;
      endcase
   endfunction
   task automatic check(input logic [47:0] got, exp_v);
      checked++;
      if (got !== exp_v) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp_v);
      end
   endtask
   task stop_test;
      if (errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (rst_n) begin
         for (int g = 0; g < 2; g++) want[g] += hit({prog_event_num[g*8+:8], prog_unit_mask[g*8+:8]});
         efix += uop_retire_valid & uop_retire_last;
      end
      ehold <= rst_n && (hit(16'hC301) || (ehold && !store_buffer_empty));
      if (cyc == 3000) begin
         errors++;
         stop_test;
      end
   end
   // Inputs here still hold what the last rising edge sampled
   always @(negedge clk_sys) begin
      if (rst_n) begin
         check(machine_clear_q, hit(16'hC308));
         check(undo_to_load_q, hit(16'hC302));
         check(fp_assist_start_q, hit(16'hC304));
         check(front_end_hold_q, ehold);
      end
   end
   initial begin
      clk_sys = 1'b1;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n, fixed_clear, act, prog_clear} = 5'h00;
      {prog_event_num, prog_unit_mask} = 32'h0;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int i = 0; i < 12; i += 2) begin
         @(negedge clk_sys);
         prog_event_num <= {tab[i+1][15:8], tab[i][15:8]};
         prog_unit_mask <= {tab[i+1][7:0], tab[i][7:0]};
         {prog_clear, fixed_clear} <= 3'h7;
         want = '{48'h0, 48'h0};
         efix = 48'h0;
         @(negedge clk_sys);
         {prog_clear, fixed_clear, act} <= 4'h1;
         repeat (200) @(negedge clk_sys);
         act <= 1'b0;
         repeat (4) @(negedge clk_sys);
         for (int g = 0; g < 2; g++) check(prog_count[g*48+:48], want[g]);
         check(fixed_count, efix);
      end
      stop_test;
   end
endmodule
`default_nettype wire
